/* File: hdl/tmrcc_pkg.sv */
// register map, field layout and codes for the timer counter channel core
`default_nettype none
package tmrcc_pkg;
  // register byte addresses, one aligned word each
  localparam logic [7:0] TMRCC_SC_ADDR      = 8'h00;
  localparam logic [7:0] TMRCC_CNTH_ADDR    = 8'h04;
  localparam logic [7:0] TMRCC_CNTL_ADDR    = 8'h08;
  localparam logic [7:0] TMRCC_MODH_ADDR    = 8'h0c;
  localparam logic [7:0] TMRCC_MODL_ADDR    = 8'h10;
  localparam logic [7:0] TMRCC_CH_BASE      = 8'h20;
  localparam logic [7:0] TMRCC_CH_STRIDE    = 8'h10;
  localparam logic [7:0] TMRCC_CH_SC_OFS    = 8'h00;
  localparam logic [7:0] TMRCC_CH_VH_OFS    = 8'h04;
  localparam logic [7:0] TMRCC_CH_VL_OFS    = 8'h08;
  // timer status control fields
  localparam int         TMRCC_OVF_BIT      = 7;
  localparam int         TMRCC_OVIE_BIT     = 6;
  localparam int         TMRCC_CPWM_BIT     = 5;
  localparam int         TMRCC_CLKS_LSB     = 3;
  localparam int         TMRCC_PS_LSB       = 0;
  // channel status control fields
  localparam int         TMRCC_CHF_BIT      = 7;
  localparam int         TMRCC_CHIE_BIT     = 6;
  localparam int         TMRCC_MSB_BIT      = 5;
  localparam int         TMRCC_MSA_BIT      = 4;
  localparam int         TMRCC_ELS_LSB      = 2;
  // clock source codes
  localparam logic [1:0] TMRCC_CLK_OFF      = 2'h0;
  localparam logic [1:0] TMRCC_CLK_BUS      = 2'h1;
  localparam logic [1:0] TMRCC_CLK_FIXED    = 2'h2;
  localparam logic [1:0] TMRCC_CLK_EXT      = 2'h3;
  // edge level codes
  localparam logic [1:0] TMRCC_ELS_GPIO     = 2'h0;
  localparam logic [1:0] TMRCC_ELS_RISE     = 2'h1;
  localparam logic [1:0] TMRCC_ELS_FALL     = 2'h2;
  localparam logic [1:0] TMRCC_ELS_BOTH     = 2'h3;
  // reset values and counter limits
  localparam logic [7:0]  TMRCC_REG_RST     = 8'h00;
  localparam logic [15:0] TMRCC_CNT_RST     = 16'h0000;
  localparam logic [15:0] TMRCC_MOD_RST     = 16'h0000;
  localparam logic [15:0] TMRCC_CNT_FULL    = 16'hffff;
  localparam logic [6:0]  TMRCC_PRE_ONES    = 7'h7f;
  // counting direction
  typedef enum logic [1:0] {
    TMRCC_DIR_UP   = 2'b01,
    TMRCC_DIR_DOWN = 2'b10
  } tmrcc_dir_t;
endpackage : tmrcc_pkg
`default_nettype wire

/* File: hdl/tmrcc_core.sv */
// timer counter core with prescaler, modulo counter and capture/compare/pwm channels
`default_nettype none

module tmrcc_core #(
  parameter int NUM_CH = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              debug_mode,
  input  wire logic              fixed_system_clock,
  input  wire logic              external_timer_clock,
  input  wire logic [NUM_CH-1:0] ch_pin_in,
  output logic      [NUM_CH-1:0] ch_pin_out,
  output logic      [NUM_CH-1:0] ch_pin_oe_n,
  output logic                   overflow_irq,
  output logic      [NUM_CH-1:0] channel_irq
);
  import tmrcc_pkg::*;

  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 8");
  end

  // bus handshake: one wait cycle, read data and read side effects taken in the wait cycle, writes taken in the ready cycle
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        rd_take;
  logic        wr_take;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  assign rd_take = psel && penable && !pready_q && !pwrite;
  assign wr_take = psel && penable && pready_q && pwrite;

  // timer status control
  logic       ovf_flag_q;
  logic       ovf_arm_q;
  logic       ovf_ie_q;
  logic       cpwm_q;
  logic [1:0] clks_q;
  logic [2:0] ps_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic        mod_pend_hi_q;
  logic        mod_pend_lo_q;
  tmrcc_dir_t  dir_q;
  logic        latched_q;
  logic        latch_hi_q;
  logic [15:0] latch_val_q;

  logic sc_hit;
  logic cnth_hit;
  logic cntl_hit;
  logic modh_hit;
  logic modl_hit;
  assign sc_hit   = (paddr == TMRCC_SC_ADDR);
  assign cnth_hit = (paddr == TMRCC_CNTH_ADDR);
  assign cntl_hit = (paddr == TMRCC_CNTL_ADDR);
  assign modh_hit = (paddr == TMRCC_MODH_ADDR);
  assign modl_hit = (paddr == TMRCC_MODL_ADDR);

  // clock source selection and prescaler
  logic       fix_prev_q;
  logic       ext_prev_q;
  logic       src_tick;
  logic [6:0] pre_q;
  logic [6:0] pre_mask;
  logic       tick;
  logic       cnt_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      fix_prev_q <= fixed_system_clock;
      ext_prev_q <= external_timer_clock;
    end
  end

  always_comb begin
    case (clks_q)
      TMRCC_CLK_BUS:   src_tick = 1'b1;
      TMRCC_CLK_FIXED: src_tick = fixed_system_clock && !fix_prev_q;
      TMRCC_CLK_EXT:   src_tick = external_timer_clock && !ext_prev_q;
      default:         src_tick = 1'b0;
    endcase
  end

  assign pre_mask = ~(TMRCC_PRE_ONES << ps_q);
  assign tick     = src_tick && !debug_mode && ((pre_q & pre_mask) == pre_mask);
  assign cnt_wr   = wr_take && (cnth_hit || cntl_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 7'h00;
    end else if (cnt_wr) begin
      pre_q <= 7'h00;
    end else if (src_tick && !debug_mode) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // counter next value and overflow event
  logic [15:0] term;
  logic [15:0] cnt_nxt;
  tmrcc_dir_t  dir_nxt;
  logic        wrap_evt;
  logic        ovf_evt;
  assign term = (mod_q == TMRCC_MOD_RST) ? TMRCC_CNT_FULL : mod_q;

  always_comb begin
    cnt_nxt  = cnt_q + 16'h0001;
    dir_nxt  = TMRCC_DIR_UP;
    wrap_evt = 1'b0;
    if (!cpwm_q) begin
      if (cnt_q == term) begin
        cnt_nxt  = TMRCC_CNT_RST;
        wrap_evt = 1'b1;
      end
    end else begin
      case (dir_q)
        TMRCC_DIR_UP: begin
          if (cnt_q >= term) begin
            cnt_nxt  = cnt_q - 16'h0001;
            dir_nxt  = TMRCC_DIR_DOWN;
            wrap_evt = 1'b1;
          end
        end
        TMRCC_DIR_DOWN: begin
          if (cnt_q == TMRCC_CNT_RST) begin
            dir_nxt = TMRCC_DIR_UP;
          end else begin
            cnt_nxt = cnt_q - 16'h0001;
            dir_nxt = TMRCC_DIR_DOWN;
          end
        end
        default: begin
          cnt_nxt = TMRCC_CNT_RST;
        end
      endcase
    end
  end

  assign ovf_evt = tick && wrap_evt && !mod_pend_hi_q && !mod_pend_lo_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= TMRCC_CNT_RST;
      dir_q <= TMRCC_DIR_UP;
    end else if (cnt_wr) begin
      cnt_q <= TMRCC_CNT_RST;
      dir_q <= TMRCC_DIR_UP;
    end else if (tick) begin
      cnt_q <= cnt_nxt;
      dir_q <= dir_nxt;
    end
  end

  // modulo bytes and pending pair tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_q         <= TMRCC_MOD_RST;
      mod_pend_hi_q <= 1'b0;
      mod_pend_lo_q <= 1'b0;
    end else if (wr_take && modh_hit) begin
      mod_q[15:8]   <= pwdata[7:0];
      mod_pend_hi_q <= !mod_pend_lo_q;
      mod_pend_lo_q <= 1'b0;
    end else if (wr_take && modl_hit) begin
      mod_q[7:0]    <= pwdata[7:0];
      mod_pend_lo_q <= !mod_pend_hi_q;
      mod_pend_hi_q <= 1'b0;
    end
  end

  // coherent counter read latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_q   <= 1'b0;
      latch_hi_q  <= 1'b0;
      latch_val_q <= TMRCC_CNT_RST;
    end else if (wr_take && (cnth_hit || cntl_hit || sc_hit)) begin
      latched_q <= 1'b0;
    end else if (rd_take && (cnth_hit || cntl_hit) && !debug_mode) begin
      if (!latched_q) begin
        latched_q   <= 1'b1;
        latch_hi_q  <= cnth_hit;
        latch_val_q <= cnt_q;
      end else if (cnth_hit != latch_hi_q) begin
        latched_q <= 1'b0;
      end
    end
  end

  // timer status control register and overflow flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ie_q <= 1'b0;
      cpwm_q   <= 1'b0;
      clks_q   <= TMRCC_CLK_OFF;
      ps_q     <= 3'h0;
    end else if (wr_take && sc_hit) begin
      ovf_ie_q <= pwdata[TMRCC_OVIE_BIT];
      cpwm_q   <= pwdata[TMRCC_CPWM_BIT];
      clks_q   <= pwdata[TMRCC_CLKS_LSB +: 2];
      ps_q     <= pwdata[TMRCC_PS_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_q <= 1'b0;
      ovf_arm_q  <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_q <= 1'b1;
      ovf_arm_q  <= 1'b0;
    end else if (wr_take && sc_hit) begin
      if (ovf_arm_q && !pwdata[TMRCC_OVF_BIT]) begin
        ovf_flag_q <= 1'b0;
      end
      ovf_arm_q <= 1'b0;
    end else if (rd_take && sc_hit && ovf_flag_q) begin
      ovf_arm_q <= 1'b1;
    end
  end

  // channels
  logic [7:0]        ch_rd [NUM_CH];
  logic [NUM_CH-1:0] ch_hit;

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    localparam logic [7:0] BASE = 8'(TMRCC_CH_BASE + n * TMRCC_CH_STRIDE);
    logic        flag_q;
    logic        arm_q;
    logic        ie_q;
    logic        msb_q;
    logic        msa_q;
    logic [1:0]  els_q;
    logic [15:0] val_q;
    logic        pin_prev_q;
    logic        pin_q;
    logic        oe_n_q;
    logic        irq_q;
    logic        sc_w;
    logic        ic;
    logic        oc;
    logic        epwm;
    logic        match;
    logic        edge_evt;
    logic        evt;
    assign sc_w     = (paddr == BASE + TMRCC_CH_SC_OFS);
    assign ch_hit[n] = sc_w || (paddr == BASE + TMRCC_CH_VH_OFS) || (paddr == BASE + TMRCC_CH_VL_OFS);
    assign ic       = !cpwm_q && !msb_q && !msa_q;
    assign oc       = !cpwm_q && !msb_q && msa_q;
    assign epwm     = !cpwm_q && msb_q;
    assign match    = tick && (cnt_nxt == val_q);
    assign edge_evt = ((els_q[0] && ch_pin_in[n] && !pin_prev_q) ||
                       (els_q[1] && !ch_pin_in[n] && pin_prev_q));
    assign evt      = ic ? edge_evt : match;

    always_comb begin
      if (sc_w) begin
        ch_rd[n] = {flag_q, ie_q, msb_q, msa_q, els_q, 2'h0};
      end else if (paddr == BASE + TMRCC_CH_VH_OFS) begin
        ch_rd[n] = val_q[15:8];
      end else if (paddr == BASE + TMRCC_CH_VL_OFS) begin
        ch_rd[n] = val_q[7:0];
      end else begin
        ch_rd[n] = TMRCC_REG_RST;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ie_q  <= 1'b0;
        msb_q <= 1'b0;
        msa_q <= 1'b0;
        els_q <= TMRCC_ELS_GPIO;
      end else if (wr_take && sc_w) begin
        ie_q  <= pwdata[TMRCC_CHIE_BIT];
        msb_q <= pwdata[TMRCC_MSB_BIT];
        msa_q <= pwdata[TMRCC_MSA_BIT];
        els_q <= pwdata[TMRCC_ELS_LSB +: 2];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_q <= 1'b0;
        arm_q  <= 1'b0;
      end else if (evt) begin
        flag_q <= 1'b1;
        arm_q  <= 1'b0;
      end else if (wr_take && sc_w) begin
        if (arm_q && !pwdata[TMRCC_CHF_BIT]) begin
          flag_q <= 1'b0;
        end
        arm_q <= 1'b0;
      end else if (rd_take && sc_w && flag_q) begin
        arm_q <= 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        val_q <= TMRCC_CNT_RST;
      end else if (ic && edge_evt && els_q != TMRCC_ELS_GPIO) begin
        val_q <= cnt_q;
      end else if (wr_take && paddr == BASE + TMRCC_CH_VH_OFS) begin
        val_q[15:8] <= pwdata[7:0];
      end else if (wr_take && paddr == BASE + TMRCC_CH_VL_OFS) begin
        val_q[7:0] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_prev_q <= 1'b0;
        pin_q      <= 1'b0;
        oe_n_q     <= 1'b1;
        irq_q      <= 1'b0;
      end else begin
        pin_prev_q <= ch_pin_in[n];
        irq_q      <= flag_q && ie_q;
        oe_n_q     <= (els_q == TMRCC_ELS_GPIO) || ic;
        if (cpwm_q && match) begin
          pin_q <= (dir_nxt == TMRCC_DIR_UP) ? els_q[0] : !els_q[0];
        end else if (epwm && match) begin
          pin_q <= els_q[0];
        end else if (epwm && tick && wrap_evt) begin
          pin_q <= !els_q[0];
        end else if (oc && match) begin
          case (els_q)
            TMRCC_ELS_RISE: pin_q <= !pin_q;
            TMRCC_ELS_FALL: pin_q <= 1'b0;
            TMRCC_ELS_BOTH: pin_q <= 1'b1;
            default:        pin_q <= pin_q;
          endcase
        end
      end
    end

    assign ch_pin_out[n]  = pin_q;
    assign ch_pin_oe_n[n] = oe_n_q;
    assign channel_irq[n] = irq_q;
  end

  // read data mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = TMRCC_REG_RST;
    if (sc_hit) begin
      rd_byte = {ovf_flag_q, ovf_ie_q, cpwm_q, clks_q, ps_q};
    end else if (cnth_hit) begin
      rd_byte = latched_q ? latch_val_q[15:8] : cnt_q[15:8];
    end else if (cntl_hit) begin
      rd_byte = latched_q ? latch_val_q[7:0] : cnt_q[7:0];
    end else if (modh_hit) begin
      rd_byte = mod_q[15:8];
    end else if (modl_hit) begin
      rd_byte = mod_q[7:0];
    end else if (|ch_hit) begin
      for (int i = 0; i < NUM_CH; i++) begin
        rd_byte = rd_byte | ch_rd[i];
      end
    end else begin
      rd_hit = 1'b0;
    end
  end

  // apb response
  logic ovf_irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      ovf_irq_q <= ovf_flag_q && ovf_ie_q;
      if (psel && penable && !pready_q) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_q <= !rd_hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign overflow_irq = ovf_irq_q;
endmodule : tmrcc_core
`default_nettype wire

/* File: test/tmrcc_core_sva.sv */
// assertion checker for the timer counter channel core bus and pin outputs
`default_nettype none
module tmrcc_core_sva
  import tmrcc_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NUM_CH-1:0] ch_pin_oe_n,
  input wire logic              overflow_irq,
  input wire logic [NUM_CH-1:0] channel_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    !pready ##1 pready;
  endsequence
  sequence ch_wr_s;
    pready && pwrite && paddr == TMRCC_CH_BASE;
  endsequence
  wait_state_a:
    assert property (setup_s |=> answer_s) else $error("answer not after one wait state");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  upper_zero_a:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a:
    assert property (pready && paddr == 8'h14 |-> pslverr) else $error("unmapped access not refused");
  mapped_ok_a:
    assert property (pready && paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20} |-> !pslverr)
      else $error("mapped access refused");
  ovf_irq_off_a:
    assert property (pready && pwrite && paddr == TMRCC_SC_ADDR && !pwdata[TMRCC_OVIE_BIT] |=> ##1 !overflow_irq)
      else $error("overflow irq with enable clear");
  ch_irq_off_a:
    assert property (ch_wr_s ##0 !pwdata[TMRCC_CHIE_BIT] |=> ##1 !channel_irq[0])
      else $error("channel irq with enable clear");
  pin_release_a:
    assert property (ch_wr_s ##0 pwdata[3:2] == TMRCC_ELS_GPIO |=> ##1 ch_pin_oe_n[0])
      else $error("pin not released");
endmodule : tmrcc_core_sva
bind tmrcc_core tmrcc_core_sva #(.NUM_CH(NUM_CH)) i_tmrcc_core_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ch_pin_oe_n(ch_pin_oe_n), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
`default_nettype wire

/* File: test/tmrcc_apb_master.sv */
// bus master model standing for the processor core
`default_nettype none
module tmrcc_apb_master (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tmrcc_apb_master
`default_nettype wire

/* File: test/tmrcc_core_tb.sv */
// self-checking testbench for the timer counter channel core
`default_nettype none
module tmrcc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmrcc_pkg::*;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } tmrcc_row_t;
  localparam logic [7:0] A_SC = TMRCC_SC_ADDR;
  localparam logic [7:0] A_CH = TMRCC_CNTH_ADDR;
  localparam logic [7:0] A_CL = TMRCC_CNTL_ADDR;
  localparam logic [7:0] A_C0 = TMRCC_CH_BASE;
  localparam logic [7:0] A_C1 = 8'h30;
  localparam tmrcc_row_t ROWS [20] = '{
    '{1'b0, A_SC, 32'h0, 1'b0}, '{1'b0, A_CH, 32'h0, 1'b0}, '{1'b0, A_CL, 32'h0, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 1'b0}, '{1'b0, A_C0, 32'h0, 1'b0},
    '{1'b0, A_C1, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 1'b1}, '{1'b1, 8'h14, 32'hff, 1'b1},
    '{1'b1, 8'h0c, 32'h12, 1'b0}, '{1'b0, 8'h0c, 32'h12, 1'b0}, '{1'b1, 8'h10, 32'h34, 1'b0},
    '{1'b0, 8'h10, 32'h34, 1'b0}, '{1'b1, A_C1, 32'hd4, 1'b0}, '{1'b0, A_C1, 32'h54, 1'b0},
    '{1'b1, A_CH, 32'hff, 1'b0}, '{1'b0, A_CH, 32'h0, 1'b0}, '{1'b1, 8'h38, 32'h05, 1'b0},
    '{1'b0, 8'h38, 32'h05, 1'b0}, '{1'b1, A_C1, 32'h0, 1'b0}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        debug_mode, aux_clk, ovf_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [1:0]  pin_in, pin_out, pin_oe_n, ch_irq, src;
  logic [2:0]  ps;
  logic        e;
  int          mismatches, comparisons;
  tmrcc_core #(.NUM_CH(2)) i_tmrcc_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_mode(debug_mode), .fixed_system_clock(aux_clk), .external_timer_clock(aux_clk),
    .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe_n(pin_oe_n),
    .overflow_irq(ovf_irq), .channel_irq(ch_irq));
  tmrcc_apb_master i_tmrcc_apb_master (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_tmrcc_apb_master.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    i_tmrcc_apb_master.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask : rdc
  task automatic rd16();
    logic [31:0] h;
    i_tmrcc_apb_master.xfer(1'b0, A_CH, 32'h0, h, e);
    i_tmrcc_apb_master.xfer(1'b0, A_CL, 32'h0, v, e);
    v = {16'h0, h[7:0], v[7:0]};
  endtask : rd16
  task automatic dbg(input logic d);
    @(posedge pclk);
    debug_mode <= d;
  endtask : dbg
  task automatic run(input int k);
    dbg(1'b0);
    repeat (k) @(posedge pclk);
    debug_mode <= 1'b1;
  endtask : run
  task automatic restart(input logic [7:0] sc);
    wr(A_SC, {24'h0, sc & 8'he7});
    dbg(1'b0);
    wr(A_CL, 32'h0);
    dbg(1'b1);
    wr(A_SC, {24'h0, sc});
  endtask : restart
  task automatic pin(input logic b);
    @(posedge pclk);
    pin_in[0] <= b;
    repeat (3) @(posedge pclk);
  endtask : pin
  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    aux_clk = 1'b0;
    forever begin
      repeat (4) @(posedge pclk);
      aux_clk <= ~aux_clk;
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0;
    debug_mode = 1'b1;
    pin_in = 2'b00;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      i_tmrcc_apb_master.xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d, q, e);
      if (!ROWS[i].w) chk("rdata", ROWS[i].d, q);
      chk("pslverr", {31'h0, ROWS[i].e}, {31'h0, e});
    end
    for (int i = 0; i < 12; i++) begin
      src = (i < 8) ? TMRCC_CLK_BUS : 2'(i - 8);
      ps = (i < 8) ? 3'(i) : 3'h0;
      restart({3'h0, src, ps});
      run(1024);
      rd16();
      chk("count", (src == TMRCC_CLK_OFF) ? 32'h0 : (src == TMRCC_CLK_BUS) ? 32'd1024 >> ps : 32'd128, v);
    end
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h09);
    restart(8'h48);
    run(9);
    rd16();
    chk("count", 32'h9, v);
    rdc("status", A_SC, 32'h48);
    run(1);
    rd16();
    chk("count", 32'h0, v);
    rdc("status", A_SC, 32'hc8);
    chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
    wr(A_SC, 32'hc8);
    rdc("status", A_SC, 32'hc8);
    wr(A_SC, 32'h48);
    rdc("status", A_SC, 32'h48);
    wr(8'h0c, 32'h0);
    restart(8'h48);
    run(10);
    rdc("status", A_SC, 32'h48);
    wr(8'h10, 32'h09);
    run(10);
    rdc("status", A_SC, 32'hc8);
    restart(8'h0f);
    rdc("cnt_lo", A_CL, 32'h0);
    dbg(1'b0);
    rdc("cnt_hi", A_CH, 32'h0);
    repeat (440) @(posedge pclk);
    rdc("cnt_lo", A_CL, 32'h0);
    rdc("cnt_lo", A_CL, 32'h3);
    wr(A_SC, 32'h0f);
    repeat (100) @(posedge pclk);
    rdc("cnt_lo", A_CL, 32'h4);
    rdc("cnt_hi", A_CH, 32'h0);
    for (int s = 1; s < 4; s++) begin
      wr(A_C0, 32'(s) << 2);
      pin(1'b1);
      rdc("capture", A_C0, {24'h0, s[0], 3'h0, 2'(s), 2'h0});
      wr(A_C0, 32'(s) << 2);
      pin(1'b0);
      rdc("capture", A_C0, {24'h0, s[1], 3'h0, 2'(s), 2'h0});
      wr(A_C0, 32'h0);
    end
    restart(8'h08);
    wr(A_C1, 32'h54);
    run(7);
    rdc("compare", A_C1, 32'hd4);
    chk("ch_irq", 32'h1, {31'h0, ch_irq[1]});
    chk("pin_out", 32'h1, {31'h0, pin_out[1]});
    chk("pin_oe_n", 32'h0, {31'h0, pin_oe_n[1]});
    wr(A_C1, 32'h0);
    repeat (2) @(posedge pclk);
    chk("pin_oe_n", 32'h1, {31'h0, pin_oe_n[1]});
    chk("ch_irq", 32'h0, {31'h0, ch_irq[1]});
    // center mode: up to modulo 9, then down; channel 1 value 5 matches both ways
    wr(A_C1, 32'h08);
    restart(8'h28);
    run(12);
    rd16();
    chk("count", 32'h6, v);
    rdc("center", A_C1, 32'h88);
    chk("pin_out", 32'h0, {31'h0, pin_out[1]});
    wr(A_C1, 32'h08);
    run(1);
    rdc("center", A_C1, 32'h88);
    chk("pin_out", 32'h1, {31'h0, pin_out[1]});
    // edge pwm, low-true: set on match, cleared again at wrap
    wr(A_C1, 32'h24);
    restart(8'h08);
    run(12);
    rdc("edge_pwm", A_C1, 32'ha4);
    chk("pin_out", 32'h0, {31'h0, pin_out[1]});
    // reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pin_oe_n", 32'h3, {30'h0, pin_oe_n});
    presetn <= 1'b1;
    rd16();
    chk("count", 32'h0, v);
    rdc("mod_lo", 8'h10, 32'h0);
    rdc("status", A_SC, 32'h0);
    print_verdict();
  end
endmodule : tmrcc_core_tb
`default_nettype wire
